/* rtl/pef_defs.svh */
// Command codes, field positions and reset values of the channel event flag registers
`ifndef PEF_DEFS_SVH
`define PEF_DEFS_SVH

// Command codes, view and clear-on-read aliases
`define PEF_CMD_DISC_VIEW   8'h04
`define PEF_CMD_DISC_CLEAR  8'h05
`define PEF_CMD_FAULT_VIEW  8'h06
`define PEF_CMD_FAULT_CLEAR 8'h07
`define PEF_CMD_START_VIEW  8'h08
`define PEF_CMD_START_CLEAR 8'h09

// Field positions, upper nibble and lower nibble
`define PEF_HI_MSB 7
`define PEF_HI_LSB 4
`define PEF_LO_MSB 3
`define PEF_LO_LSB 0

// Reset values
`define PEF_FLAGS_RESET 8'h00
`define PEF_NIB_RESET   4'h0
`define PEF_PORT_RESET  2'h0

// Latest time between both channels ready and paired flags set
`define PEF_PAIR_SET_MS     5
`define PEF_CLK_HZ          100000000
`define PEF_PAIR_SET_CYCLES ((`PEF_PAIR_SET_MS * `PEF_CLK_HZ) / 1000)

`endif

/* rtl/pef_pkg.sv */
// Types shared by the channel event flag block
package pef_pkg;

  // Port operating mode
  typedef enum logic [2:0] {
    PEF_MODE_MANUAL = 3'b001,
    PEF_MODE_SEMI   = 3'b010,
    PEF_MODE_AUTO   = 3'b100
  } pef_mode_type;

endpackage : pef_pkg

/* rtl/pef_event_flags.sv */
// Per-channel event flag registers with view and clear-on-read command aliases
// What this block does
// - Class flags set per class cycle, or only on class change when reporting changes.
// - Detect flags set per detect cycle, or only on detection change when enabled.
// - 4-pair port without power-on request sets detect flags only when both channels ready.
// - 4-pair port without power-on request sets both detect flags together after both channels finish.
// - Single-signature 4-pair load sets only the classified channel's class flag.
// - Dual-signature discovery: semi-auto sets class flags together, manual individually.
// - Dual-signature with power-on request or auto mode sets flags per channel.
// - Code 06h reads fault flags; 07h reads them and clears them.
// - Turning a channel off clears that channel's event flags.
// - Clear-on-read releases the pending summary; any set bit feeds the summary.
// - Fault flags: disconnect in bits 7-4, overload timeout in bits 3-0, reset 0.
// - Overload flags update per channel on 4-pair ports; disconnect flags do on dual-signature ones.
// - Single-signature disconnect sets both channel flags; dual-signature sets its own.
// - Overload flag still sets on timeout even when overload cut is disabled.
// - Clearing the overload flag leaves the limit and overload counters untouched.
// - Code 08h reads start/limit flags; 09h reads them and clears them.
// - Bits 7-4 flag current held at the limit longer than the limit timeout.
// - Bits 3-0 flag start timeout, or classification or detection error.
// - Current-limit and start-fault flags update per channel on 4-pair ports.
// - Auto mode: invalid discovery results never set start-fault flags.
// - Power-enable change sets the matching start fault's companion flag, outside here.
`timescale 1ns/10ps
`default_nettype none
`include "pef_defs.svh"

module pef_event_flags (
  input  wire logic                  ref_clk,
  input  wire logic                  rstn,
  input  wire logic                  cmd_valid,
  input  wire logic [7:0]            cmd_code,
  output logic      [7:0]            rd_data,
  output logic                       rd_valid,
  input  wire pef_pkg::pef_mode_type op_mode,
  input  wire logic                  class_change_report_enable,
  input  wire logic                  detect_change_report_enable,
  input  wire logic [1:0]            four_pair_port,
  input  wire logic [1:0]            dual_signature,
  input  wire logic [3:0]            power_on_request,
  input  wire logic [3:0]            detect_done,
  input  wire logic [3:0]            detect_changed,
  input  wire logic [3:0]            class_done,
  input  wire logic [3:0]            class_changed,
  input  wire logic [3:0]            disconnect_seen,
  input  wire logic [3:0]            overload_timeout,
  input  wire logic [3:0]            limit_timeout,
  input  wire logic [3:0]            startup_timeout,
  input  wire logic [3:0]            discovery_error,
  input  wire logic [3:0]            channel_off,
  output logic                       discovery_pending,
  output logic                       fault_pending,
  output logic                       start_limit_pending
);

  typedef struct packed {
    logic [7:0] disc;
    logic [7:0] fault;
    logic [7:0] start;
    logic [3:0] det_wait;
    logic [3:0] cls_wait;
    logic [7:0] rd_data;
    logic       rd_valid;
    logic       disc_any;
    logic       fault_any;
    logic       start_any;
  } pef_state_type;

  pef_state_type cur;
  pef_state_type next_cur;

  // Pair merge: held events release on both channels of a paired port at once
  function automatic logic [7:0] pef_pair_merge(input logic [3:0] wait_in,
                                                input logic [3:0] now,
                                                input logic [1:0] together);
    logic [3:0] acc;
    logic [3:0] set;
    logic [3:0] hold;
    int         p;
    acc  = wait_in | now;
    // Unpaired ports release any held event at once, so none is lost
    set  = acc;
    hold = `PEF_NIB_RESET;
    for (p = 0; p < 2; p++) begin
      if (together[p]) begin
        if (&acc[2*p +: 2]) begin
          set[2*p +: 2]  = 2'b11;
          hold[2*p +: 2] = 2'b00;
        end else begin
          set[2*p +: 2]  = 2'b00;
          hold[2*p +: 2] = acc[2*p +: 2];
        end
      end
    end
    return {hold, set};
  endfunction : pef_pair_merge

  // Widen a per-port mask to its two channels
  function automatic logic [3:0] pef_port_to_chan(input logic [1:0] port);
    return {port[1], port[1], port[0], port[0]};
  endfunction : pef_port_to_chan

  logic [1:0] power_on_request_port;
  logic       is_auto;
  logic [1:0] det_together;
  logic [1:0] cls_together;
  logic [3:0] det_evt;
  logic [3:0] cls_evt;
  logic [7:0] det_merge;
  logic [7:0] cls_merge;
  logic [3:0] ss_chan;
  logic [3:0] disc_evt;
  logic [3:0] start_evt;
  logic [7:0] set_disc;
  logic [7:0] set_fault;
  logic [7:0] set_start;
  logic [7:0] off_mask;

  // Event sources and pairing of channels on 4-pair ports
  always_comb begin
    power_on_request_port    = {|power_on_request[3:2], |power_on_request[1:0]};
    is_auto      = (op_mode == pef_pkg::PEF_MODE_AUTO);
    det_together = four_pair_port & ~power_on_request_port
                   & ~(dual_signature & {2{is_auto}});
    cls_together = four_pair_port & dual_signature & ~power_on_request_port
                   & {2{op_mode == pef_pkg::PEF_MODE_SEMI}};
    det_evt      = detect_done
                   & (~{4{detect_change_report_enable}} | detect_changed);
    cls_evt      = class_done
                   & (~{4{class_change_report_enable}} | class_changed);
    det_merge    = pef_pair_merge(cur.det_wait, det_evt, det_together);
    cls_merge    = pef_pair_merge(cur.cls_wait, cls_evt, cls_together);
    ss_chan      = pef_port_to_chan(four_pair_port & ~dual_signature);
    disc_evt     = disconnect_seen
                   | (ss_chan & {disconnect_seen[2], disconnect_seen[3],
                                 disconnect_seen[0], disconnect_seen[1]});
    start_evt    = startup_timeout
                   | (discovery_error & ~{4{is_auto}});
    set_disc     = {cls_merge[3:0], det_merge[3:0]};
    set_fault    = {disc_evt, overload_timeout};
    set_start    = {limit_timeout, start_evt};
    off_mask     = {channel_off, channel_off};
  end

  // Next state: reads, clear-on-read and flag updates
  always_comb begin
    logic [7:0] clr_disc;
    logic [7:0] clr_fault;
    logic [7:0] clr_start;
    clr_disc           = `PEF_FLAGS_RESET;
    clr_fault          = `PEF_FLAGS_RESET;
    clr_start          = `PEF_FLAGS_RESET;
    next_cur           = cur;
    next_cur.rd_valid  = 1'b0;
    if (cmd_valid) begin
      next_cur.rd_valid = 1'b1;
      unique case (cmd_code)
        `PEF_CMD_DISC_VIEW:   next_cur.rd_data = cur.disc;
        `PEF_CMD_DISC_CLEAR: begin
          next_cur.rd_data = cur.disc;
          clr_disc         = cur.disc;
        end
        `PEF_CMD_FAULT_VIEW:  next_cur.rd_data = cur.fault;
        `PEF_CMD_FAULT_CLEAR: begin
          next_cur.rd_data = cur.fault;
          clr_fault        = cur.fault;
        end
        `PEF_CMD_START_VIEW:  next_cur.rd_data = cur.start;
        `PEF_CMD_START_CLEAR: begin
          next_cur.rd_data = cur.start;
          clr_start        = cur.start;
        end
        default:              next_cur.rd_data = `PEF_FLAGS_RESET;
      endcase
    end
    // Set wins over any clear in the same cycle
    next_cur.disc      = (cur.disc & ~clr_disc & ~off_mask) | set_disc;
    next_cur.fault     = (cur.fault & ~clr_fault & ~off_mask) | set_fault;
    next_cur.start     = (cur.start & ~clr_start & ~off_mask) | set_start;
    next_cur.det_wait  = det_merge[7:4] & ~channel_off;
    next_cur.cls_wait  = cls_merge[7:4] & ~channel_off;
    next_cur.disc_any  = |next_cur.disc;
    next_cur.fault_any = |next_cur.fault;
    next_cur.start_any = |next_cur.start;
  end

  // State register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from flip-flops
  assign rd_data             = cur.rd_data;
  assign rd_valid            = cur.rd_valid;
  assign discovery_pending   = cur.disc_any;
  assign fault_pending       = cur.fault_any;
  assign start_limit_pending = cur.start_any;

  // Checks
  AST_FAULT_CLR: assert property (@(posedge ref_clk) disable iff (!rstn)
    cmd_valid && cmd_code == `PEF_CMD_FAULT_CLEAR && set_fault == 8'h00
      && channel_off == 4'h0 |=> cur.fault == 8'h00 && rd_data == $past(cur.fault))
    else $error("fault clear-on-read did not clear");

  AST_FAULT_VIEW: assert property (@(posedge ref_clk) disable iff (!rstn)
    cmd_valid && cmd_code == `PEF_CMD_FAULT_VIEW && channel_off == 4'h0
      |=> (cur.fault & $past(cur.fault)) == $past(cur.fault))
    else $error("fault view changed the register");

  AST_START_CLR: assert property (@(posedge ref_clk) disable iff (!rstn)
    cmd_valid && cmd_code == `PEF_CMD_START_CLEAR |=> rd_valid
      && rd_data == $past(cur.start) && (cur.start & ~$past(set_start)) == 8'h00)
    else $error("start/limit clear-on-read wrong");

  AST_SET_WINS: assert property (@(posedge ref_clk) disable iff (!rstn)
    cmd_valid && cmd_code == `PEF_CMD_FAULT_CLEAR && set_fault[0]
      |=> cur.fault[0])
    else $error("event lost during clear-on-read");

  AST_OFF_CLEARS: assert property (@(posedge ref_clk) disable iff (!rstn)
    channel_off[1] && !limit_timeout[1] && !start_evt[1] |=> !cur.start[1] && !cur.start[5])
    else $error("channel off left flags set");

  AST_SS_DISC: assert property (@(posedge ref_clk) disable iff (!rstn)
    four_pair_port[0] && !dual_signature[0] && disconnect_seen[0]
      |=> cur.fault[4] && cur.fault[5])
    else $error("single-signature disconnect not on both channels");

  AST_AUTO_NO_START: assert property (@(posedge ref_clk) disable iff (!rstn)
    is_auto && startup_timeout == 4'h0 |=> (cur.start[3:0] & ~$past(cur.start[3:0])) == 4'h0)
    else $error("auto mode set start fault from discovery");

  AST_DET_PAIRED: assert property (@(posedge ref_clk) disable iff (!rstn)
    det_together[0] |=> cur.disc[0] == cur.disc[1] || $past(cur.disc[1:0]) != 2'b00
      || $past(channel_off[1:0]) != 2'b00)
    else $error("paired detect flags set apart");

  AST_PENDING: assert property (@(posedge ref_clk) disable iff (!rstn)
    fault_pending == (cur.fault != 8'h00) && discovery_pending == (cur.disc != 8'h00))
    else $error("summary does not follow flags");

  AST_DET_EVT: assert property (@(posedge ref_clk) disable iff (!rstn)
    detect_done[2] && !detect_change_report_enable && four_pair_port[1] == 1'b0
      |=> cur.disc[2])
    else $error("detect flag not set after detection cycle");

  // Read alias checks
  AST_RD_VALID: assert property (@(posedge ref_clk) disable iff (!rstn)
    cmd_valid |=> rd_valid)
    else $error("read not answered");

  AST_RD_QUIET: assert property (@(posedge ref_clk) disable iff (!rstn)
    !cmd_valid |=> !rd_valid)
    else $error("answer without a read");

  AST_START_VIEW: assert property (@(posedge ref_clk) disable iff (!rstn)
    cmd_valid && cmd_code == `PEF_CMD_START_VIEW && channel_off == 4'h0
      |=> rd_data == $past(cur.start) && (cur.start & $past(cur.start)) == $past(cur.start))
    else $error("start/limit view changed the register");

  AST_DISC_CLR: assert property (@(posedge ref_clk) disable iff (!rstn)
    cmd_valid && cmd_code == `PEF_CMD_DISC_CLEAR
      |=> rd_data == $past(cur.disc) && cur.disc == $past(set_disc))
    else $error("discovery clear-on-read kept returned bits");

  AST_DISC_RELEASE: assert property (@(posedge ref_clk) disable iff (!rstn)
    cmd_valid && cmd_code == `PEF_CMD_DISC_CLEAR && set_disc == 8'h00
      |=> !discovery_pending)
    else $error("discovery summary not released by clear-on-read");

  AST_FAULT_RELEASE: assert property (@(posedge ref_clk) disable iff (!rstn)
    cmd_valid && cmd_code == `PEF_CMD_FAULT_CLEAR && set_fault == 8'h00
      |=> !fault_pending)
    else $error("fault summary not released by clear-on-read");

  AST_START_RELEASE: assert property (@(posedge ref_clk) disable iff (!rstn)
    cmd_valid && cmd_code == `PEF_CMD_START_CLEAR && set_start == 8'h00
      |=> !start_limit_pending)
    else $error("start/limit summary not released by clear-on-read");

  // Discovery flag checks
  AST_CLS_EVT: assert property (@(posedge ref_clk) disable iff (!rstn)
    class_done[3] && !class_change_report_enable && !four_pair_port[1]
      |=> cur.disc[7])
    else $error("class flag not set after classification cycle");

  AST_CLS_CHG_ONLY: assert property (@(posedge ref_clk) disable iff (!rstn)
    class_change_report_enable && !class_changed[2] && !four_pair_port[1]
      && cur.cls_wait[2] == 1'b0 |=> !cur.disc[6] || $past(cur.disc[6]))
    else $error("class flag set without a class change");

  AST_DET_CHG_ONLY: assert property (@(posedge ref_clk) disable iff (!rstn)
    detect_change_report_enable && !detect_changed[2] && !four_pair_port[1]
      && cur.det_wait[2] == 1'b0 |=> !cur.disc[2] || $past(cur.disc[2]))
    else $error("detect flag set without a detection change");

  AST_SS_CLASS: assert property (@(posedge ref_clk) disable iff (!rstn)
    four_pair_port[0] && !dual_signature[0] && class_done[0] && !class_done[1]
      && !class_change_report_enable && cur.cls_wait[1:0] == 2'b00
      |=> cur.disc[4] && (cur.disc[5] == $past(cur.disc[5]) || $past(cmd_valid)
      || $past(channel_off[1])))
    else $error("single-signature class flag set on both channels");

  AST_CLS_PAIRED: assert property (@(posedge ref_clk) disable iff (!rstn)
    cls_together[0] |=> cur.disc[4] == cur.disc[5] || $past(cur.disc[5:4]) != 2'b00
      || $past(channel_off[1:0]) != 2'b00)
    else $error("paired class flags set apart");

  AST_REPOWER_OWN: assert property (@(posedge ref_clk) disable iff (!rstn)
    four_pair_port[0] && power_on_request[1] && detect_done[1]
      && !detect_change_report_enable |=> cur.disc[1])
    else $error("requested channel did not set its own detect flag");

  AST_OFF_DISC: assert property (@(posedge ref_clk) disable iff (!rstn)
    channel_off[1] && !set_disc[1] && !set_disc[5] |=> !cur.disc[1] && !cur.disc[5])
    else $error("channel off left discovery flags set");

  // Fault and start/limit flag checks
  AST_DUAL_DISC: assert property (@(posedge ref_clk) disable iff (!rstn)
    four_pair_port[0] && dual_signature[0] && disconnect_seen[1] && !disconnect_seen[0]
      |=> cur.fault[5] && (cur.fault[4] == $past(cur.fault[4]) || $past(cmd_valid)
      || $past(channel_off[0])))
    else $error("dual-signature disconnect spread to the other channel");

  AST_OVL_SET: assert property (@(posedge ref_clk) disable iff (!rstn)
    overload_timeout[3] |=> cur.fault[3])
    else $error("overload timeout flag not set");

  AST_LIM_SET: assert property (@(posedge ref_clk) disable iff (!rstn)
    limit_timeout[2] |=> cur.start[6])
    else $error("limit timeout flag not set");

  AST_STRT_SET: assert property (@(posedge ref_clk) disable iff (!rstn)
    startup_timeout[0] |=> cur.start[0])
    else $error("start timeout flag not set");

  COV_FAULT_CLR: cover property (@(posedge ref_clk) disable iff (!rstn)
    cur.fault != 8'h00 ##1 cmd_valid && cmd_code == `PEF_CMD_FAULT_CLEAR);
  COV_PAIR_DET: cover property (@(posedge ref_clk) disable iff (!rstn)
    det_together[0] && det_evt[0] && !det_evt[1] ##[1:20] det_evt[1]);
  COV_SS_DISC: cover property (@(posedge ref_clk) disable iff (!rstn)
    ss_chan[0] && disconnect_seen[1]);
  COV_START_CLR: cover property (@(posedge ref_clk) disable iff (!rstn)
    cur.start != 8'h00 ##1 cmd_valid && cmd_code == `PEF_CMD_START_CLEAR);
  COV_REPOWER: cover property (@(posedge ref_clk) disable iff (!rstn)
    four_pair_port[0] && power_on_request[1] && detect_done[1]);

endmodule : pef_event_flags

`default_nettype wire

/* verification/pef_host_model.sv */
// Host model issuing command-byte register reads
`timescale 1ns/10ps
`default_nettype none

module pef_host_model (
  input  wire logic       ref_clk,
  output logic            cmd_valid,
  output logic [7:0]      cmd_code,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid
);
  logic [7:0] last_byte;
  logic       answered;

  // Idle bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_code  = 8'h00;
  end

  // One read, code held through the taking edge
  task automatic read(input logic [7:0] code);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_code  <= code;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    cmd_code  <= ~code;  // Released code no longer shows the last value
    @(negedge ref_clk);
    answered  = rd_valid;
    last_byte = rd_data;
  endtask : read
endmodule : pef_host_model
`default_nettype wire

/* verification/test_pef_event_flags.sv */
// Self-checking bench of the channel event flag registers
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin failures++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, got); end end

module test_pef_event_flags;
  logic                  ref_clk, rstn, cmd_valid, rd_valid, cce, dce, disc_p, fault_p, sl_p;
  logic [7:0]            cmd_code, rd_data;
  logic [1:0]            fpp, dual;
  logic [3:0]            pwr, dd, dch, cd, cch, dis, ovl, lim, sto, derr, off, a, b;
  pef_pkg::pef_mode_type mode;
  int                    failures, num_checks;
  int                    cyc = 0;

  pef_event_flags dut_u (
    .ref_clk(ref_clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .rd_data(rd_data), .rd_valid(rd_valid), .op_mode(mode),
    .class_change_report_enable(cce), .detect_change_report_enable(dce),
    .four_pair_port(fpp), .dual_signature(dual), .power_on_request(pwr),
    .detect_done(dd), .detect_changed(dch), .class_done(cd), .class_changed(cch),
    .disconnect_seen(dis), .overload_timeout(ovl), .limit_timeout(lim),
    .startup_timeout(sto), .discovery_error(derr), .channel_off(off),
    .discovery_pending(disc_p), .fault_pending(fault_p), .start_limit_pending(sl_p)
  );

  pef_host_model host_u (
    .ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .rd_data(rd_data), .rd_valid(rd_valid)
  );

  // Free-running 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Expected register byte from upper and lower channel nibbles
  function automatic logic [7:0] pack(input logic [3:0] hi, input logic [3:0] lo);
    return {hi, lo};
  endfunction : pack

  // Read one alias and compare the answer
  task automatic rd(input logic [7:0] code, input logic [7:0] ex, input string nm);
    host_u.read(code);
    `CHK("rd_valid", 1'b1, host_u.answered)
    `CHK(nm, ex, host_u.last_byte)
  endtask : rd

  // Ends one cycle of event pulses
  task automatic step;
    @(posedge ref_clk);
    {dd, dch, cd, cch, dis, ovl, lim, sto, derr, off} <= 40'h0;
  endtask : step

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  // Hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      failures++;
      give_verdict();
    end
  end

  // Main sequence
  initial begin
    void'($urandom(32'h8E79DA1E));
    {rstn, cce, dce, fpp, dual, pwr} = 11'h0;
    {dd, dch, cd, cch, dis, ovl, lim, sto, derr, off} = 40'h0;
    mode = pef_pkg::PEF_MODE_MANUAL;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int c = 4; c < 11; c++) rd(c[7:0], 8'h00, "reset or unmapped");
    $display("test reset done");
    a = 4'($urandom);
    b = 4'($urandom) | 4'h1;
    @(posedge ref_clk);
    {dis, ovl} <= {a, b};
    step();
    @(negedge ref_clk);
    `CHK("fault_pending", 1'b1, fault_p)
    rd(8'h06, pack(a, b), "fault view");
    rd(8'h07, pack(a, b), "fault clear");
    rd(8'h06, 8'h00, "fault after clear");
    `CHK("fault_pending", 1'b0, fault_p)
    $display("test fault done");
    a = 4'($urandom) | 4'h1;
    b = 4'($urandom);
    @(posedge ref_clk);
    {lim, sto, derr} <= {a, b, 4'h8};
    step();
    @(negedge ref_clk);
    `CHK("start_limit_pending", 1'b1, sl_p)
    rd(8'h08, pack(a, b | 4'h8), "start view");
    rd(8'h09, pack(a, b | 4'h8), "start clear");
    @(posedge ref_clk);
    mode <= pef_pkg::PEF_MODE_AUTO;
    derr <= 4'hF;
    step();
    rd(8'h09, 8'h00, "auto discovery error");
    $display("test start done");
    @(posedge ref_clk);
    mode <= pef_pkg::PEF_MODE_MANUAL;
    {dis, ovl, lim, sto} <= 16'hFFFF;
    step();
    @(posedge ref_clk);
    off <= 4'h2;
    step();
    rd(8'h06, 8'hDD, "channel off");
    rd(8'h08, 8'hDD, "start channel off");
    fork
      rd(8'h07, 8'hDD, "clear during event");
      begin
        @(posedge ref_clk);
        ovl <= 4'h1;
        step();
      end
    join
    rd(8'h07, 8'h01, "event survives clear");
    $display("test clear done");
    a = 4'($urandom) | 4'h4;
    b = 4'($urandom) | 4'h8;
    @(posedge ref_clk);
    {dd, cd} <= {a, b};
    step();
    @(negedge ref_clk);
    `CHK("discovery_pending", 1'b1, disc_p)
    rd(8'h05, pack(b, a), "cycle flags");
    `CHK("discovery_pending", 1'b0, disc_p)
    @(posedge ref_clk);
    {cce, dce, dd, cd, dch, cch} <= {2'b11, 16'hFF28};
    step();
    rd(8'h05, 8'h82, "change flags");
    $display("test discovery done");
    @(posedge ref_clk);
    {fpp, cce, dce, dd} <= {2'b01, 2'b00, 4'h1};
    step();
    rd(8'h04, 8'h00, "pair first half");
    @(posedge ref_clk);
    dd <= 4'h2;
    step();
    rd(8'h05, 8'h03, "pair both");
    @(posedge ref_clk);
    {cd, dis} <= 8'h11;
    step();
    rd(8'h05, 8'h10, "single signature class");
    rd(8'h07, 8'h30, "single signature disconnect");
    @(posedge ref_clk);
    mode <= pef_pkg::PEF_MODE_SEMI;
    {dual, cd, dis} <= 10'h112;
    step();
    rd(8'h04, 8'h00, "dual semi first");
    rd(8'h07, 8'h20, "dual disconnect");
    @(posedge ref_clk);
    cd <= 4'h2;
    step();
    rd(8'h05, 8'h30, "dual semi both");
    @(posedge ref_clk);
    mode <= pef_pkg::PEF_MODE_MANUAL;
    cd <= 4'h2;
    step();
    rd(8'h05, 8'h20, "dual manual");
    @(posedge ref_clk);
    mode <= pef_pkg::PEF_MODE_AUTO;
    dd <= 4'h2;
    step();
    rd(8'h04, 8'h02, "dual auto");
    @(posedge ref_clk);
    off <= 4'h2;
    step();
    rd(8'h04, 8'h00, "off clears discovery");
    @(posedge ref_clk);
    mode <= pef_pkg::PEF_MODE_SEMI;
    {pwr, dd} <= 8'h22;
    step();
    rd(8'h04, 8'h02, "re-power own flag");
    $display("test four pair done");
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    `CHK("pending in reset", 3'b000, {disc_p, fault_p, sl_p})
    rstn <= 1'b1;
    rd(8'h08, 8'h00, "start after reset");
    $display("test mid reset done");
    give_verdict();
  end
endmodule : test_pef_event_flags
`default_nettype wire
